// file: rtl/smseq_regs.vh
`ifndef SMSEQ_REGS_VH
`define SMSEQ_REGS_VH

// Timebase
`define SMSEQ_CLK_NS 40
`define SMSEQ_TICK_NS 1000000

// Byte addresses of the register words
`define SMSEQ_CTRL_ADDR 8'h00
`define SMSEQ_TIMEOUT_ADDR 8'h04
`define SMSEQ_SENSWIN_ADDR 8'h08
`define SMSEQ_BLIND_ADDR 8'h0c
`define SMSEQ_ENDMUTE_ADDR 8'h10
`define SMSEQ_STATUS_ADDR 8'h14

// Control word fields
`define SMSEQ_CTRL_LMODE 0
`define SMSEQ_CTRL_WITH_EN 1
`define SMSEQ_CTRL_EN_ONLY 2
`define SMSEQ_CTRL_DIR_LO 3
`define SMSEQ_CTRL_DIR_HI 4
`define SMSEQ_CTRL_CLOSE_SENSOR 5
`define SMSEQ_CTRL_BLIND_EN 6
`define SMSEQ_CTRL_MIN_EN 7
`define SMSEQ_CTRL_WIDTH 8

// Direction codes
`define SMSEQ_DIR_UP 2'h0
`define SMSEQ_DIR_DOWN 2'h1
`define SMSEQ_DIR_BOTH_WAYS 2'h2

// Reset values, times in milliseconds
`define SMSEQ_CTRL_RST 8'h10
`define SMSEQ_TIMEOUT_RST 24'h002710
`define SMSEQ_SENSWIN_RST 24'h001388
`define SMSEQ_BLIND_RST 24'h0000fa
`define SMSEQ_ENDMUTE_RST 24'h0009c4

// Least gap between the two sensors of a pair, milliseconds
`define SMSEQ_MIN_PAIR_MS 24'h000096

`endif

// file: rtl/smseq_top.v
// Overview of operation
// - concurrent: near pair both occupied within window
// - reverse travel: far pair starts muting
// - concurrent start needs sensors clear, curtain free
// - timeout ends muting at once; zero unlimited
// - without enable option muting always enabled
// - enable/disable: only rising enable edge arms
// - enable/disable: falling enable edge cancels muting
// - enable-only: enable never cancels; rearm needs low
// - direction setting restricts which pair leads
// - sensor closing: third sensor release ends muting
// - concurrent blind time only with curtain closing
// - blind time forces curtain output high
// - pair gap over maximum rejects the start
// - minimum option: pair gap must exceed 150 ms
// - L mode: two sensors, either order, window
// - L start needs both sensors clear, curtain free
// - L mode: freed opening ends muting
// - L end timer from first release ends muting
//
// Local design decisions: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "smseq_regs.vh"

module smseq_top #(
  parameter TICK_CYCLES = `SMSEQ_TICK_NS / `SMSEQ_CLK_NS
) (
  input wire mclk_i,
  input wire reset_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire first_near_sensor_i,
  input wire second_near_sensor_i,
  input wire first_far_sensor_i,
  input wire second_far_sensor_i,
  input wire curtain_i,
  input wire enable_i,
  output reg curtain_out_o,
  output reg muting_o
);

  // One-hot sequencer states
  localparam [4:0] ST_WAIT = 5'h01;
  localparam [4:0] ST_READY = 5'h02;
  localparam [4:0] ST_PAIR = 5'h04;
  localparam [4:0] ST_MUTE = 5'h08;
  localparam [4:0] ST_BLIND = 5'h10;
  localparam [31:0] TICK_FULL = TICK_CYCLES - 1;
  localparam [15:0] TICK_LAST = TICK_FULL[15:0];

  // True for the states that force the curtain output high
  function smseq_forced;
    input [4:0] st;
    begin
      smseq_forced = (st == ST_MUTE) | (st == ST_BLIND);
    end
  endfunction

  // Byte-lane merge of a 24-bit register with bus write data
  function [23:0] smseq_merge;
    input [23:0] old;
    input [31:0] dat;
    input [3:0] sel;
    begin
      smseq_merge[7:0] = sel[0] ? dat[7:0] : old[7:0];
      smseq_merge[15:8] = sel[1] ? dat[15:8] : old[15:8];
      smseq_merge[23:16] = sel[2] ? dat[23:16] : old[23:16];
    end
  endfunction

  // Pin synchroniser stages and edge history
  reg [5:0] sync1_r;
  reg [5:0] sync2_r;
  reg en_d_r;
  reg cur_d_r;

  // Millisecond timebase
  reg [15:0] div_r;
  reg tick_r;

  // Configuration registers
  reg [7:0] ctrl_r;
  reg [23:0] timeout_r;
  reg [23:0] senswin_r;
  reg [23:0] blind_r;
  reg [23:0] endmute_r;

  // Sequencer state, arming and cycle timers
  reg [4:0] state_r;
  reg [4:0] state_nxt;
  reg pair_far_r;
  reg pair_far_nxt;
  reg armed_r;
  reg [23:0] tm_r;
  reg [23:0] endm_r;
  reg endm_run_r;
  reg third_seen_r;
  reg start_nxt;
  reg end_cond;

  // Two-stage synchronisers for all pins
  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      sync1_r <= 6'h10;
      sync2_r <= 6'h10;
      en_d_r <= 1'b0;
      cur_d_r <= 1'b1;
    end else begin
      sync1_r <= {enable_i, curtain_i, second_far_sensor_i,
                  first_far_sensor_i, second_near_sensor_i,
                  first_near_sensor_i};
      sync2_r <= sync1_r;
      en_d_r <= sync2_r[5];
      cur_d_r <= sync2_r[4];
    end
  end

  // Synchronised pins and their edges
  wire s1 = sync2_r[0];
  wire s2 = sync2_r[1];
  wire s3 = sync2_r[2];
  wire s4 = sync2_r[3];
  wire cur = sync2_r[4];
  wire en = sync2_r[5];
  wire en_rise = en & ~en_d_r;
  wire en_fall = ~en & en_d_r;
  wire cur_rise = cur & ~cur_d_r;

  // Configuration fields
  wire lmode = ctrl_r[`SMSEQ_CTRL_LMODE];
  wire with_en = ctrl_r[`SMSEQ_CTRL_WITH_EN];
  wire en_only = ctrl_r[`SMSEQ_CTRL_EN_ONLY];
  wire [1:0] dir = ctrl_r[`SMSEQ_CTRL_DIR_HI:`SMSEQ_CTRL_DIR_LO];
  wire close_sensor = ctrl_r[`SMSEQ_CTRL_CLOSE_SENSOR];
  wire blind_en = ctrl_r[`SMSEQ_CTRL_BLIND_EN];
  wire min_en = ctrl_r[`SMSEQ_CTRL_MIN_EN];

  // Far pair is ignored entirely in L mode
  wire near_any = s1 | s2;
  wire far_any = ~lmode & (s3 | s4);
  wire all_clear = ~near_any & ~far_any;
  wire near_ok = lmode | (dir != `SMSEQ_DIR_DOWN);
  wire far_ok = ~lmode & (dir != `SMSEQ_DIR_UP);
  wire pair_all = pair_far_r ? (s3 & s4) : (s1 & s2);
  wire pair_one = pair_far_r ? (s3 | s4) : (s1 | s2);
  wire other_any = pair_far_r ? near_any : far_any;
  wire third = pair_far_r ? s2 : s3;
  wire cancel = with_en & ~en_only & en_fall;
  wire blind_ok = blind_en & (lmode | ~close_sensor);
  wire timed_out = (timeout_r != 24'h000000) & (tm_r >= timeout_r);
  // A latent arm never survives a switch into the enable option
  wire armed = ~with_en | armed_r;
  // Pair gap against the window and the optional minimum
  wire gap_over = tm_r > senswin_r;
  wire gap_ok = ~min_en | (tm_r > `SMSEQ_MIN_PAIR_MS);
  // L mode closes on a free opening or an expired end timer
  wire l_free = all_clear & cur;
  wire l_expired = endm_run_r & (endm_r >= endmute_r);

  // Millisecond timebase divider
  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      div_r <= 16'h0000;
      tick_r <= 1'b0;
    end else if (div_r == TICK_LAST) begin
      div_r <= 16'h0000;
      tick_r <= 1'b1;
    end else begin
      div_r <= div_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end

  // Closing condition of an active cycle
  always @* begin
    end_cond = 1'b0;
    if (lmode) begin
      end_cond = l_free | l_expired;
    end else if (close_sensor) begin
      end_cond = third_seen_r & ~third;
    end else begin
      end_cond = cur_rise;
    end
  end

  // Cycle sequencer
  always @* begin
    state_nxt = state_r;
    pair_far_nxt = pair_far_r;
    start_nxt = 1'b0;
    case (state_r)
      ST_WAIT: begin
        if (all_clear & cur) begin
          state_nxt = ST_READY;
        end
      end
      ST_READY: begin
        if (~cur) begin
          state_nxt = ST_WAIT;
        end else if (armed & near_ok & near_any & ~far_any) begin
          state_nxt = ST_PAIR;
          pair_far_nxt = 1'b0;
        end else if (armed & far_ok & far_any & ~near_any) begin
          state_nxt = ST_PAIR;
          pair_far_nxt = 1'b1;
        end else if (~all_clear) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_PAIR: begin
        if (~cur | other_any | ~pair_one | cancel) begin
          state_nxt = ST_WAIT;
        end else if (gap_over) begin
          state_nxt = ST_WAIT;
        end else if (pair_all) begin
          if (gap_ok) begin
            state_nxt = ST_MUTE;
            start_nxt = 1'b1;
          end else begin
            state_nxt = ST_WAIT;
          end
        end
      end
      ST_MUTE: begin
        if (cancel | timed_out) begin
          state_nxt = ST_WAIT;
        end else if (end_cond) begin
          state_nxt = blind_ok ? ST_BLIND : ST_WAIT;
        end
      end
      ST_BLIND: begin
        if (tm_r >= blind_r) begin
          state_nxt = ST_WAIT;
        end
      end
      default: begin
        state_nxt = ST_WAIT;
      end
    endcase
  end

  // Every state change restarts the cycle timers
  wire tm_clr = state_nxt != state_r;

  // State and leading pair
  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= ST_WAIT;
      pair_far_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pair_far_r <= pair_far_nxt;
    end
  end

  // Arming: only an enable rising edge arms, a start consumes it
  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      armed_r <= 1'b0;
    end else if (~with_en) begin
      armed_r <= 1'b0;
    end else if (en_rise) begin
      armed_r <= 1'b1;
    end else if (cancel | start_nxt) begin
      armed_r <= 1'b0;
    end
  end

  // Cycle timer in ticks, saturating
  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      tm_r <= 24'h000000;
    end else if (tm_clr) begin
      tm_r <= 24'h000000;
    end else if (tick_r & ~(&tm_r)) begin
      tm_r <= tm_r + 24'h000001;
    end
  end

  // End-of-muting timer, started by the first release in L mode
  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      endm_run_r <= 1'b0;
      endm_r <= 24'h000000;
    end else if (tm_clr) begin
      endm_run_r <= 1'b0;
      endm_r <= 24'h000000;
    end else begin
      if ((state_r == ST_MUTE) & lmode & (~s1 | ~s2)) begin
        endm_run_r <= 1'b1;
      end
      if (endm_run_r & tick_r & ~(&endm_r)) begin
        endm_r <= endm_r + 24'h000001;
      end
    end
  end

  // Third sensor of the sequence seen occupied during muting
  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      third_seen_r <= 1'b0;
    end else if (tm_clr) begin
      third_seen_r <= 1'b0;
    end else if ((state_r == ST_MUTE) & third) begin
      third_seen_r <= 1'b1;
    end
  end

  // Effective curtain output and muting status
  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      curtain_out_o <= 1'b0;
      muting_o <= 1'b0;
    end else begin
      curtain_out_o <= cur | smseq_forced(state_nxt);
      muting_o <= state_nxt == ST_MUTE;
    end
  end

  // A held request is taken once; the ack cycle blocks a repeat
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr = wb_req & wb_we_i;

  // Wishbone classic slave, one wait state
  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      ctrl_r <= `SMSEQ_CTRL_RST;
      timeout_r <= `SMSEQ_TIMEOUT_RST;
      senswin_r <= `SMSEQ_SENSWIN_RST;
      blind_r <= `SMSEQ_BLIND_RST;
      endmute_r <= `SMSEQ_ENDMUTE_RST;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_wr & wb_sel_i[0] & (wb_adr_i == `SMSEQ_CTRL_ADDR)) begin
        ctrl_r <= wb_dat_i[7:0];
      end
      if (wb_wr & (wb_adr_i == `SMSEQ_TIMEOUT_ADDR)) begin
        timeout_r <= smseq_merge(timeout_r, wb_dat_i, wb_sel_i);
      end
      if (wb_wr & (wb_adr_i == `SMSEQ_SENSWIN_ADDR)) begin
        senswin_r <= smseq_merge(senswin_r, wb_dat_i, wb_sel_i);
      end
      if (wb_wr & (wb_adr_i == `SMSEQ_BLIND_ADDR)) begin
        blind_r <= smseq_merge(blind_r, wb_dat_i, wb_sel_i);
      end
      if (wb_wr & (wb_adr_i == `SMSEQ_ENDMUTE_ADDR)) begin
        endmute_r <= smseq_merge(endmute_r, wb_dat_i, wb_sel_i);
      end
      if (wb_req & ~wb_we_i) begin
        case (wb_adr_i)
          `SMSEQ_CTRL_ADDR: wb_dat_o <= {24'h000000, ctrl_r};
          `SMSEQ_TIMEOUT_ADDR: wb_dat_o <= {8'h00, timeout_r};
          `SMSEQ_SENSWIN_ADDR: wb_dat_o <= {8'h00, senswin_r};
          `SMSEQ_BLIND_ADDR: wb_dat_o <= {8'h00, blind_r};
          `SMSEQ_ENDMUTE_ADDR: wb_dat_o <= {8'h00, endmute_r};
          `SMSEQ_STATUS_ADDR: begin
            wb_dat_o <= {16'h0000, 3'h0, state_r, pair_far_r,
                         armed, en, cur, s4, s3, s2, s1};
          end
          default: wb_dat_o <= 32'h00000000;
        endcase
      end else begin
        wb_dat_o <= 32'h00000000;
      end
    end
  end

endmodule // smseq_top

// file: verification/smseq_asserts.sv
`timescale 1ns/1ps
module smseq_asserts #(
  parameter TICK_CYCLES = 4
) (
  input wire mclk_i,
  input wire reset_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire first_near_sensor_i,
  input wire second_near_sensor_i,
  input wire first_far_sensor_i,
  input wire second_far_sensor_i,
  input wire curtain_i,
  input wire enable_i,
  input wire curtain_out_o,
  input wire muting_o
);
  reg [7:0] ctrl_r;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // Shadow of the control word, taken at the acknowledged write
  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i)
      ctrl_r <= 8'h10;
    else if (wb_ack_o && wb_we_i && wb_cyc_i && wb_adr_i == 8'h00 &&
             wb_sel_i[0])
      ctrl_r <= wb_dat_i[7:0];
  end
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("request not answered");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  mute_force_a: assert property (muting_o |-> curtain_out_o)
    else $error("curtain output low while muting");
  curt_fall_a: assert property ($fell(curtain_out_o)
    |-> !$past(curtain_i, 3)) else $error("output fell, curtain free");
  mute_pair_a: assert property ($rose(muting_o) |->
    ($past(first_near_sensor_i, 3) && $past(second_near_sensor_i, 3)) ||
    ($past(first_far_sensor_i, 3) && $past(second_far_sensor_i, 3)))
    else $error("muting without a full pair");
  mute_free_a: assert property ($rose(muting_o)
    |-> $past(curtain_i, 3)) else $error("muting with curtain broken");
  mute_cancel_a: assert property (ctrl_r[1] && !ctrl_r[2] &&
    $fell(enable_i) |-> ##[1:5] !muting_o)
    else $error("enable fall did not cancel");
  blind_hold_a: assert property ($fell(muting_o) && ctrl_r[6] &&
    !ctrl_r[5] && $past(curtain_i, 3) && !$past(curtain_i, 4)
    |-> curtain_out_o [*3]) else $error("blind time not held");
endmodule // smseq_asserts

bind smseq_top smseq_asserts #(.TICK_CYCLES(TICK_CYCLES)) chk (
  .mclk_i(mclk_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .first_near_sensor_i(first_near_sensor_i),
  .second_near_sensor_i(second_near_sensor_i),
  .first_far_sensor_i(first_far_sensor_i),
  .second_far_sensor_i(second_far_sensor_i), .curtain_i(curtain_i),
  .enable_i(enable_i), .curtain_out_o(curtain_out_o), .muting_o(muting_o));

// file: verification/smseq_bench.sv
`timescale 1ns/1ps
`include "smseq_regs.vh"
module smseq_bench;
  reg mclk_i = 0;
  reg reset_i = 1;
  reg cyc = 0;
  reg we = 0;
  reg [7:0] adr = 0;
  reg [3:0] sel = 4'hf;
  reg [3:0] lanes = 4'hf;
  reg [31:0] wd = 0;
  reg enable_i = 1;
  reg [31:0] q;
  wire [31:0] rd;
  wire [4:0] pv;
  wire ack, cout, mute;
  integer err_count = 0;
  integer compares = 0;
  initial begin
    forever #20 mclk_i = ~mclk_i;
  end
  smseq_sensors pal (.mclk_i(mclk_i), .pins_o(pv));
  smseq_top #(.TICK_CYCLES(4)) uut (.mclk_i(mclk_i), .reset_i(reset_i),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
    .first_near_sensor_i(pv[4]), .second_near_sensor_i(pv[3]),
    .first_far_sensor_i(pv[2]), .second_far_sensor_i(pv[1]),
    .curtain_i(pv[0]), .enable_i(enable_i), .curtain_out_o(cout),
    .muting_o(mute));
  task check(input [31:0] s, input [31:0] e);
    begin
      compares = compares + 1;
      if (s !== e) begin
        err_count = err_count + 1;
        $display("[ERR] %0t got %h expected %h", $time, s, e);
      end
    end
  endtask
  // One Wishbone classic cycle, released at the edge that sees ack
  // Only the watchdog ends a wait for ack
  task bus(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge mclk_i);
      cyc <= 1;
      we <= w;
      adr <= a;
      sel <= lanes;
      wd <= d;
      @(posedge mclk_i);
      while (ack !== 1'b1) begin
        @(posedge mclk_i);
      end
      q = rd;
      cyc <= 0;
      wd <= ~d;
    end
  endtask
  task wmut(input v, input integer n);
    begin
      while (mute !== v && n > 0) begin
        n = n - 1;
        @(posedge mclk_i);
      end
    end
  endtask
  // Curtain broken by the load, then freed again
  task fin;
    begin
      pal.put(5'h06, 8);
      check(cout, 1);
      pal.put(5'h07, 8);
      check(mute, 0);
    end
  endtask
  task s_regs;
    begin
      bus(0, `SMSEQ_CTRL_ADDR, 0);
      check(q, `SMSEQ_CTRL_RST);
      bus(0, `SMSEQ_TIMEOUT_ADDR, 0);
      check(q, `SMSEQ_TIMEOUT_RST);
      bus(0, `SMSEQ_SENSWIN_ADDR, 0);
      check(q, `SMSEQ_SENSWIN_RST);
      bus(0, `SMSEQ_BLIND_ADDR, 0);
      check(q, `SMSEQ_BLIND_RST);
      bus(0, `SMSEQ_ENDMUTE_ADDR, 0);
      check(q, `SMSEQ_ENDMUTE_RST);
      bus(1, 8'h18, 32'h5a);
      bus(0, 8'h18, 0);
      check(q, 0);
      bus(0, `SMSEQ_STATUS_ADDR, 0);
      check(q, 32'h270);
      lanes = 4'h1;
      bus(1, `SMSEQ_ENDMUTE_ADDR, 32'hffffff14);
      lanes = 4'hf;
      bus(0, `SMSEQ_ENDMUTE_ADDR, 0);
      check(q, 32'h914);
      bus(1, `SMSEQ_SENSWIN_ADDR, 200);
      bus(1, `SMSEQ_BLIND_ADDR, 10);
    end
  endtask
  task s_blind;
    begin
      bus(1, `SMSEQ_CTRL_ADDR, 32'h40);
      pal.lead(0, 40);
      check(mute, 1);
      fin;
      pal.put(5'h06, 16);
      check(cout, 1);
      pal.put(5'h06, 60);
      check(cout, 0);
    end
  endtask
  task s_dir;
    begin
      bus(1, `SMSEQ_CTRL_ADDR, 32'h00);
      pal.lead(1, 40);
      wmut(1, 20);
      check(mute, 0);
      bus(1, `SMSEQ_CTRL_ADDR, 32'h08);
      pal.lead(1, 40);
      check(mute, 1);
      fin;
    end
  endtask
  // Gap of 50, 250 and 175 ticks against min 150 and max 200
  task s_win;
    begin
      bus(1, `SMSEQ_CTRL_ADDR, 32'h90);
      pal.lead(0, 200);
      wmut(1, 20);
      check(mute, 0);
      pal.lead(0, 1000);
      wmut(1, 20);
      check(mute, 0);
      pal.lead(0, 700);
      check(mute, 1);
      fin;
    end
  endtask
  task s_tmo;
    begin
      bus(1, `SMSEQ_CTRL_ADDR, 32'h10);
      bus(1, `SMSEQ_TIMEOUT_ADDR, 30);
      pal.lead(0, 40);
      wmut(0, 95);
      check(mute, 1);
      wmut(0, 40);
      check(mute, 0);
      bus(1, `SMSEQ_TIMEOUT_ADDR, 0);
    end
  endtask
  task s_en;
    begin
      bus(1, `SMSEQ_CTRL_ADDR, 32'h12);
      pal.lead(0, 40);
      wmut(1, 20);
      check(mute, 0);
      enable_i <= 0;
      repeat (4) @(posedge mclk_i);
      enable_i <= 1;
      pal.lead(0, 40);
      check(mute, 1);
      enable_i <= 0;
      wmut(0, 10);
      check(mute, 0);
      bus(1, `SMSEQ_CTRL_ADDR, 32'h16);
      enable_i <= 1;
      pal.lead(0, 40);
      enable_i <= 0;
      repeat (10) @(posedge mclk_i);
      check(mute, 1);
      fin;
    end
  endtask
  // Sensor closing: curtain return keeps muting, third release ends it
  task s_sens;
    begin
      bus(1, `SMSEQ_CTRL_ADDR, 32'h60);
      pal.lead(0, 40);
      check(mute, 1);
      pal.put(5'h1e, 8);
      pal.put(5'h06, 8);
      pal.put(5'h07, 8);
      check(mute, 1);
      pal.put(5'h03, 8);
      check(mute, 0);
      pal.put(5'h02, 8);
      check(cout, 0);
    end
  endtask
  // L mode: free opening ends muting, then the end timer does
  task s_lmode;
    begin
      bus(1, `SMSEQ_CTRL_ADDR, 32'h01);
      bus(1, `SMSEQ_ENDMUTE_ADDR, 20);
      pal.lead(0, 40);
      check(mute, 1);
      pal.put(5'h18, 8);
      pal.put(5'h00, 8);
      check(mute, 1);
      pal.put(5'h01, 8);
      check(mute, 0);
      pal.lead(0, 40);
      pal.put(5'h08, 40);
      check(mute, 1);
      wmut(0, 80);
      check(mute, 0);
    end
  endtask
  task summarize;
    begin
      $display("checks %0d errors %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  initial begin
    #2000000;
    err_count = err_count + 1;
    summarize;
  end
  initial begin
    repeat (3) @(posedge mclk_i);
    reset_i <= 0;
    s_regs;
    s_blind;
    s_dir;
    s_win;
    s_tmo;
    s_en;
    s_sens;
    s_lmode;
    summarize;
  end
endmodule // smseq_bench

// file: verification/smseq_sensors.sv
`timescale 1ns/1ps
module smseq_sensors (
  input wire mclk_i,
  output reg [4:0] pins_o
);
  // Pin order: near1, near2, far1, far2, curtain (1 = free)
  initial pins_o = 5'h01;
  task put(input [4:0] v, input integer n);
    begin
      @(posedge mclk_i);
      pins_o <= v;
      repeat (n) @(posedge mclk_i);
    end
  endtask
  // Opening clear, then one pair entered with a gap of gap+1 cycles
  task lead(input far, input integer gap);
    begin
      put(5'h01, 12);
      put(far ? 5'h05 : 5'h11, gap);
      put(far ? 5'h07 : 5'h19, 12);
    end
  endtask
endmodule // smseq_sensors
